/* config_word_pkg.sv */
// shared constants for the configuration word and reset sequencer
package config_word_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned POWERUP_DELAY_TIMER_MS      = 72;
  localparam int unsigned BOR_MS       = 72;
  localparam int unsigned POWERUP_DELAY_TIMER_CYC     = POWERUP_DELAY_TIMER_MS * (CLK_HZ / 1000);
  localparam int unsigned BOR_CYC      = BOR_MS * (CLK_HZ / 1000);
  localparam int unsigned OST_CYC      = 1024;
  localparam int unsigned WDT_TICKS    = 256;
  localparam int unsigned CNT_W        = 22;
  localparam int unsigned WDT_W        = 16;

  // ---------------------------------------------------------------
  // configuration word
  // ---------------------------------------------------------------
  localparam int unsigned CFG_W        = 14;
  localparam logic [13:0] CFG_ERASED   = 14'h3FFF;
  localparam logic [13:0] CFG_LOC      = 14'h2007;
  localparam logic [13:0] SPACE_LO     = 14'h2000;
  localparam logic [13:0] SPACE_HI     = 14'h3FFF;
  localparam int unsigned OSC_LSB      = 0;
  localparam int unsigned WDT_BIT      = 2;
  localparam int unsigned POWERUP_DELAY_TIMER_BIT     = 3;
  localparam int unsigned CP_LO_LSB    = 4;
  localparam int unsigned BOR_BIT      = 6;
  localparam int unsigned PAR_BIT      = 7;
  localparam int unsigned CP_HI_LSB    = 8;

  typedef enum logic [1:0] {
    low_power_crystal      = 2'h0,
    std_crystal_resonator  = 2'h1,
    high_speed_crystal     = 2'h2,
    resistor_capacitor_osc = 2'h3
  } osc_mode_t;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_PROG_ADDR = 8'h00;
  localparam logic [7:0] REG_PROG_DATA = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h10;
  localparam logic [7:0] REG_CTRL      = 8'h14;

  // status fields
  localparam int unsigned ST_OSC_LSB   = 0;
  localparam int unsigned ST_WDT_BIT   = 4;
  localparam int unsigned ST_POWERUP_DELAY_TIMER_BIT  = 5;
  localparam int unsigned ST_BOR_BIT   = 6;
  localparam int unsigned ST_PAR_BIT   = 7;
  localparam int unsigned ST_PROG_BIT  = 8;
  localparam int unsigned ST_STATE_LSB = 16;

  // control fields (write-one pulses)
  localparam int unsigned CTRL_SLEEP   = 0;
  localparam int unsigned CTRL_WDT_CLR = 1;

  // event bits of irq status and mask
  localparam int unsigned EV_W         = 6;
  localparam int unsigned EV_POR       = 0;
  localparam int unsigned EV_BOR       = 1;
  localparam int unsigned EV_WDT       = 2;
  localparam int unsigned EV_PAR       = 3;
  localparam int unsigned EV_MCLR      = 4;
  localparam int unsigned EV_WAKE      = 5;

  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

/* sync_2ff.sv */
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module sync_2ff #(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,     // system clock
  input  wire logic         aresetn,  // synchronous reset, active low
  input  wire logic [W-1:0] rst_val,  // constant value held in reset
  input  wire logic [W-1:0] d,        // asynchronous inputs
  output logic      [W-1:0] q         // synchronised outputs
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= rst_val;
      q      <= rst_val;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule

/* config_word_reset_options.sv */
// configuration word store, option decode and reset/sleep sequencer
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps

module config_word_reset_options #(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = config_word_pkg::POWERUP_DELAY_TIMER_CYC,
  parameter int unsigned BOR_CYCLES  = config_word_pkg::BOR_CYC
) (
  input  wire logic        aclk,           // system clock, 25 MHz
  input  wire logic        aresetn,        // synchronous reset, active low
  input  wire logic        awvalid,        // write address valid
  output logic             awready,        // write address ready
  input  wire logic [7:0]  awaddr,         // write byte address
  input  wire logic [2:0]  awprot,         // write protection, unused
  input  wire logic        wvalid,         // write data valid
  output logic             wready,         // write data ready
  input  wire logic [31:0] wdata,          // write data
  input  wire logic [3:0]  wstrb,          // write byte strobes
  output logic             bvalid,         // write response valid
  input  wire logic        bready,         // write response ready
  output logic [1:0]       bresp,          // write response code
  input  wire logic        arvalid,        // read address valid
  output logic             arready,        // read address ready
  input  wire logic [7:0]  araddr,         // read byte address
  input  wire logic [2:0]  arprot,         // read protection, unused
  output logic             rvalid,         // read data valid
  input  wire logic        rready,         // read data ready
  output logic [31:0]      rdata,          // read data
  output logic [1:0]       rresp,          // read response code
  input  wire logic        por_n,          // power-good pin, low = no power
  input  wire logic        mclr_n,         // external reset pin, active low
  input  wire logic        brownout_det,   // brown-out detector level
  input  wire logic        prog_mode,      // programming mode pin
  input  wire logic        wdt_rc_osc,     // watchdog rc oscillator
  input  wire logic        fetch_valid,    // program word fetched
  input  wire logic [13:0] fetch_word,     // fetched program word
  input  wire logic        fetch_parity,   // stored even-parity bit
  input  wire logic        irq_wake,       // enabled interrupt pending
  output logic             core_reset_n,   // core reset, active low
  output logic             core_sleep,     // core in sleep
  output logic [1:0]       osc_mode_select,       // oscillator mode
  output logic             watchdog_enable_cfg,   // watchdog enabled
  output logic             powerup_delay_enable,  // power-up timer on
  output logic             brownout_reset_enable, // brown-out reset on
  output logic             parity_check_enable,   // parity check on
  output logic [7:0]       code_protect_sel,      // code protect pairs
  output logic             irq                    // interrupt, active high
);

  // ---------------------------------------------------------------
  // types and pin synchronisers
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    st_load  = 7'h01,
    st_powerup_delay_timer  = 7'h02,
    st_bor   = 7'h04,
    st_hold  = 7'h08,
    st_ost   = 7'h10,
    st_run   = 7'h20,
    st_sleep = 7'h40
  } rst_state_t;

  logic [4:0] pins_s;
  logic       por_s;
  logic       mclr_s;
  logic       bod_s;
  logic       prog_s;
  logic       rc_s;

  sync_2ff #(.W(5)) pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rst_val (5'h02),
    .d       ({wdt_rc_osc, prog_mode, brownout_det, mclr_n, por_n}),
    .q       (pins_s)
  );

  assign por_s  = pins_s[0];
  assign mclr_s = pins_s[1];
  assign bod_s  = pins_s[2];
  assign prog_s = pins_s[3];
  assign rc_s   = pins_s[4];

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  logic        aw_full_r, aw_full_nxt;
  logic        w_full_r, w_full_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic        do_write;
  logic [31:0] wmask;
  logic [31:0] wval;

  logic [13:0] cfg_word_r, cfg_word_nxt;
  logic [13:0] prog_addr_r, prog_addr_nxt;
  logic [config_word_pkg::EV_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [config_word_pkg::EV_W-1:0] irq_mask_r, irq_mask_nxt;
  logic [config_word_pkg::EV_W-1:0] events;
  logic        irq_r, irq_nxt;
  logic        sleep_req;
  logic        wdt_clr;
  logic        cfg_ok;
  logic        rd_cfg_ok;
  logic [31:0] status_word;

  rst_state_t  state_r, state_nxt;
  logic [13:0] opt_r, opt_nxt;

  assign awready  = !aw_full_r && !bvalid_r;
  assign wready   = !w_full_r && !bvalid_r;
  assign arready  = !rvalid_r;
  assign bvalid   = bvalid_r;
  assign bresp    = bresp_r;
  assign rvalid   = rvalid_r;
  assign rdata    = rdata_r;
  assign rresp    = rresp_r;
  assign do_write = aw_full_r && w_full_r && !bvalid_r;
  assign wmask    = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                     {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wval     = w_data_r & wmask;

  // config space open only in programming mode, inside its range
  assign cfg_ok    = prog_s && (prog_addr_r >= config_word_pkg::SPACE_LO)
                     && (prog_addr_r <= config_word_pkg::SPACE_HI);
  assign rd_cfg_ok = cfg_ok;

  assign status_word = {9'h000, state_r, 7'h00, prog_s,
                        opt_r[config_word_pkg::PAR_BIT],
                        opt_r[config_word_pkg::BOR_BIT],
                        powerup_delay_enable,
                        opt_r[config_word_pkg::WDT_BIT],
                        2'h0, opt_r[1:0]};

  always_comb begin
    aw_full_nxt   = aw_full_r;
    aw_addr_nxt   = aw_addr_r;
    w_full_nxt    = w_full_r;
    w_data_nxt    = w_data_r;
    w_strb_nxt    = w_strb_r;
    bvalid_nxt    = bvalid_r;
    bresp_nxt     = bresp_r;
    cfg_word_nxt  = cfg_word_r;
    prog_addr_nxt = prog_addr_r;
    irq_mask_nxt  = irq_mask_r;
    sleep_req     = 1'b0;
    wdt_clr       = 1'b0;
    irq_stat_nxt  = irq_stat_r;
    if (awvalid && awready) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_full_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = config_word_pkg::RESP_OKAY;
      case (aw_addr_r)
        config_word_pkg::REG_PROG_ADDR: begin
          prog_addr_nxt = (prog_addr_r & ~wmask[13:0]) | wval[13:0];
        end
        config_word_pkg::REG_PROG_DATA: begin
          if (!cfg_ok) begin
            bresp_nxt = config_word_pkg::RESP_SLVERR;
          end else if (prog_addr_r == config_word_pkg::CFG_LOC) begin
            // programming only clears bits; unstrobed lanes stay
            cfg_word_nxt = cfg_word_r
                           & (wval[13:0] | ~wmask[13:0]);
          end
        end
        config_word_pkg::REG_STATUS: begin
        end
        config_word_pkg::REG_IRQ_STAT: begin
          irq_stat_nxt = irq_stat_r
                         & ~wval[config_word_pkg::EV_W-1:0];
        end
        config_word_pkg::REG_IRQ_MASK: begin
          irq_mask_nxt = (irq_mask_r & ~wmask[config_word_pkg::EV_W-1:0])
                         | wval[config_word_pkg::EV_W-1:0];
        end
        config_word_pkg::REG_CTRL: begin
          sleep_req = wval[config_word_pkg::CTRL_SLEEP];
          wdt_clr   = wval[config_word_pkg::CTRL_WDT_CLR];
        end
        default: begin
          bresp_nxt = config_word_pkg::RESP_SLVERR;
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    irq_stat_nxt = irq_stat_nxt | events;
    irq_nxt      = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = 32'h0000_0000;
      rresp_nxt  = config_word_pkg::RESP_OKAY;
      case (araddr)
        config_word_pkg::REG_PROG_ADDR: begin
          rdata_nxt = {18'h00000, prog_addr_r};
        end
        config_word_pkg::REG_PROG_DATA: begin
          if (!rd_cfg_ok) begin
            rresp_nxt = config_word_pkg::RESP_SLVERR;
          end else if (prog_addr_r == config_word_pkg::CFG_LOC) begin
            rdata_nxt = {18'h00000, cfg_word_r};
          end else begin
            rdata_nxt = {18'h00000, config_word_pkg::CFG_ERASED};
          end
        end
        config_word_pkg::REG_STATUS: begin
          rdata_nxt = status_word;
        end
        config_word_pkg::REG_IRQ_STAT: begin
          rdata_nxt = {26'h0000000, irq_stat_r};
        end
        config_word_pkg::REG_IRQ_MASK: begin
          rdata_nxt = {26'h0000000, irq_mask_r};
        end
        config_word_pkg::REG_CTRL: begin
        end
        default: begin
          rresp_nxt = config_word_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // watchdog on its own rc oscillator
  // ---------------------------------------------------------------
  logic                                rc_d_r, rc_d_nxt;
  logic                                rc_tick;
  logic [config_word_pkg::WDT_W-1:0]   wdt_cnt_r, wdt_cnt_nxt;
  logic                                wdt_run;
  logic                                wdt_to;

  assign rc_tick = rc_s && !rc_d_r;
  assign wdt_run = opt_r[config_word_pkg::WDT_BIT]
                   && (state_r == st_run || state_r == st_sleep);
  assign wdt_to  = wdt_run && rc_tick && (wdt_cnt_r ==
                   config_word_pkg::WDT_W'(config_word_pkg::WDT_TICKS - 1));

  always_comb begin
    rc_d_nxt    = rc_s;
    wdt_cnt_nxt = wdt_cnt_r;
    if (!wdt_run || wdt_clr || wdt_to) begin
      wdt_cnt_nxt = '0;
    end else if (rc_tick) begin
      wdt_cnt_nxt = wdt_cnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // reset and sleep sequencer
  // ---------------------------------------------------------------
  logic [config_word_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic                              crystal;
  logic                              powerup_delay_timer_on;
  logic                              par_err;
  logic                              rst_n_nxt;
  rst_state_t                        after_rst;

  assign crystal  = opt_r[1:0] != config_word_pkg::resistor_capacitor_osc;
  assign powerup_delay_timer_on  = !cfg_word_r[config_word_pkg::POWERUP_DELAY_TIMER_BIT]
                    || cfg_word_r[config_word_pkg::BOR_BIT];
  assign after_rst = crystal ? st_ost : st_run;
  assign par_err  = fetch_valid && opt_r[config_word_pkg::PAR_BIT]
                    && (^{fetch_word, fetch_parity});

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = '0;
    opt_nxt   = opt_r;
    events    = '0;
    if (!por_s) begin
      state_nxt = st_load;
    end else if (opt_r[config_word_pkg::BOR_BIT] && bod_s) begin
      if (state_r != st_bor) begin
        events[config_word_pkg::EV_BOR] = 1'b1;
      end
      state_nxt = st_bor;
    end else if (!mclr_s || prog_s) begin
      if (!mclr_s && state_r != st_hold) begin
        events[config_word_pkg::EV_MCLR] = 1'b1;
      end
      state_nxt = st_hold;
    end else begin
      case (state_r)
        st_load: begin
          opt_nxt = cfg_word_r;
          events[config_word_pkg::EV_POR] = 1'b1;
          if (powerup_delay_timer_on) begin
            state_nxt = st_powerup_delay_timer;
          end else begin
            state_nxt = (opt_nxt[1:0] !=
                         config_word_pkg::resistor_capacitor_osc)
                        ? st_ost : st_run;
          end
        end
        st_powerup_delay_timer: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == config_word_pkg::CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin
            state_nxt = after_rst;
          end
        end
        st_bor: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == config_word_pkg::CNT_W'(BOR_CYCLES - 1)) begin
            state_nxt = after_rst;
          end
        end
        st_hold: begin
          state_nxt = after_rst;
        end
        st_ost: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r ==
              config_word_pkg::CNT_W'(config_word_pkg::OST_CYC - 1)) begin
            state_nxt = st_run;
          end
        end
        st_run: begin
          if (wdt_to) begin
            events[config_word_pkg::EV_WDT] = 1'b1;
            state_nxt = st_hold;
          end else if (par_err) begin
            events[config_word_pkg::EV_PAR] = 1'b1;
            state_nxt = st_hold;
          end else if (sleep_req) begin
            state_nxt = st_sleep;
          end
        end
        st_sleep: begin
          if (wdt_to || irq_wake) begin
            events[config_word_pkg::EV_WAKE] = 1'b1;
            state_nxt = after_rst;
          end
        end
        default: begin
          state_nxt = st_load;
        end
      endcase
    end
    rst_n_nxt = (state_nxt == st_run) || (state_nxt == st_sleep);
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  logic rst_n_r;
  logic sleep_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r   <= 1'b0;
      aw_addr_r   <= 8'h00;
      w_full_r    <= 1'b0;
      w_data_r    <= 32'h0000_0000;
      w_strb_r    <= 4'h0;
      bvalid_r    <= 1'b0;
      bresp_r     <= 2'h0;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h0000_0000;
      rresp_r     <= 2'h0;
      cfg_word_r  <= config_word_pkg::CFG_ERASED;
      prog_addr_r <= config_word_pkg::CFG_LOC;
      irq_stat_r  <= '0;
      irq_mask_r  <= '0;
      irq_r       <= 1'b0;
      rc_d_r      <= 1'b0;
      wdt_cnt_r   <= '0;
      state_r     <= st_load;
      cnt_r       <= '0;
      opt_r       <= config_word_pkg::CFG_ERASED;
      rst_n_r     <= 1'b0;
      sleep_r     <= 1'b0;
    end else begin
      aw_full_r   <= aw_full_nxt;
      aw_addr_r   <= aw_addr_nxt;
      w_full_r    <= w_full_nxt;
      w_data_r    <= w_data_nxt;
      w_strb_r    <= w_strb_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      rvalid_r    <= rvalid_nxt;
      rdata_r     <= rdata_nxt;
      rresp_r     <= rresp_nxt;
      cfg_word_r  <= cfg_word_nxt;
      prog_addr_r <= prog_addr_nxt;
      irq_stat_r  <= irq_stat_nxt;
      irq_mask_r  <= irq_mask_nxt;
      irq_r       <= irq_nxt;
      rc_d_r      <= rc_d_nxt;
      wdt_cnt_r   <= wdt_cnt_nxt;
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      opt_r       <= opt_nxt;
      rst_n_r     <= rst_n_nxt;
      sleep_r     <= state_nxt == st_sleep;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign core_reset_n          = rst_n_r;
  assign core_sleep            = sleep_r;
  assign irq                   = irq_r;
  assign osc_mode_select       = opt_r[1:0];
  assign watchdog_enable_cfg   = opt_r[config_word_pkg::WDT_BIT];
  assign powerup_delay_enable  = !opt_r[config_word_pkg::POWERUP_DELAY_TIMER_BIT]
                                 || opt_r[config_word_pkg::BOR_BIT];
  assign brownout_reset_enable = opt_r[config_word_pkg::BOR_BIT];
  assign parity_check_enable   = opt_r[config_word_pkg::PAR_BIT];
  assign code_protect_sel      = {opt_r[13:8], opt_r[5:4]};

endmodule

/* cwro_chk.sv */
// assertions on the option outputs and reset sequencer of the block
`timescale 1ns/10ps
module cwro_chk (
  input wire logic        aclk,                  // clock
  input wire logic        aresetn,               // reset
  input wire logic        rvalid,                // r valid
  input wire logic        rready,                // r ready
  input wire logic [31:0] rdata,                 // r data
  input wire logic        brownout_det,          // brown-out
  input wire logic        fetch_valid,           // fetch
  input wire logic [13:0] fetch_word,            // word
  input wire logic        fetch_parity,          // parity
  input wire logic        irq_wake,              // wake
  input wire logic        core_reset_n,          // core reset
  input wire logic        core_sleep,            // sleep
  input wire logic [1:0]  osc_mode_select,       // osc
  input wire logic        watchdog_enable_cfg,   // wdt
  input wire logic        powerup_delay_enable,  // powerup_delay_timer
  input wire logic        brownout_reset_enable, // bor
  input wire logic        parity_check_enable,   // parity
  input wire logic [7:0]  code_protect_sel       // protect
);
  logic [15:0] low_r;
  logic [15:0] low_nxt;
  logic [13:0] opts;
  assign opts = {code_protect_sel, parity_check_enable,
    brownout_reset_enable, powerup_delay_enable, watchdog_enable_cfg,
    osc_mode_select};
  // cycles the core has been held in reset
  always_comb low_nxt = core_reset_n ? 16'h0000 : low_r + {15'h0000, ~&low_r};
  always_ff @(posedge aclk) low_r <= aresetn ? low_nxt : 16'h0000;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_bod; brownout_reset_enable && brownout_det; endsequence
  sequence s_wake; core_sleep && irq_wake; endsequence
  sequence s_par;
    parity_check_enable && core_reset_n && !core_sleep && fetch_valid
      && ^{fetch_word, fetch_parity};
  endsequence
  AST_ERASED: assert property ($rose(aresetn) |-> opts == 14'h3FFF)
    else $error("options not erased");
  AST_FORCED: assert property (brownout_reset_enable |-> powerup_delay_enable)
    else $error("power-up delay not forced");
  AST_FIXED: assert property (core_reset_n && $past(core_reset_n) |-> $stable(opts))
    else $error("options changed at run time");
  AST_WAKE: assert property (s_wake |-> ##[1:3] !core_sleep)
    else $error("no wake");
  AST_PARITY: assert property (s_par |-> ##[1:3] !core_reset_n)
    else $error("no parity reset");
  AST_BOR: assert property (s_bod |=> ##3 !core_reset_n [*8])
    else $error("brown-out hold short");
  AST_OST: assert property ($rose(core_reset_n) && osc_mode_select != 2'h3
    |-> low_r >= 16'h0400)
    else $error("crystal start-up hold short");
  AST_RHOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule
bind config_word_reset_options cwro_chk i_chk (.*);

/* cfg_programmer.sv */
// programmer model: axi4-lite master plus programming pin
`timescale 1ns/10ps
module cfg_programmer (
  input  wire logic        aclk,     // clock
  output logic             awvalid,  // aw valid
  input  wire logic        awready,  // aw ready
  output logic [7:0]       awaddr,   // aw addr
  output logic             wvalid,   // w valid
  input  wire logic        wready,   // w ready
  output logic [31:0]      wdata,    // w data
  input  wire logic        bvalid,   // b valid
  output logic             bready,   // b ready
  output logic             arvalid,  // ar valid
  input  wire logic        arready,  // ar ready
  output logic [7:0]       araddr,   // ar addr
  input  wire logic        rvalid,   // r valid
  output logic             rready,   // r ready
  output logic             prog_mode // program pin
);
  initial {awvalid, wvalid, bready, arvalid, rready, prog_mode} = 6'h00;
  initial {awaddr, wdata, araddr} = 48'h0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge aclk);
      ad = ad | awready;
      dd = dd | wready;
      @(posedge aclk);
      awvalid <= !ad;
      wvalid <= !dd;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input int dly);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    repeat (dly) @(posedge aclk);
    rready <= 1'b1;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // option word goes to its fixed place, only with the pin raised
  task automatic burn(input logic [13:0] word);
    prog_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    wr(8'h00, 32'h2007);
    wr(8'h04, {18'h0, word});
  endtask
  task automatic leave;
    prog_mode <= 1'b0;
  endtask
endmodule

/* testbench.sv */
// self-checking bench for the option word and reset sequencer
`timescale 1ns/10ps
module testbench;
  logic aclk = 0, aresetn, por_n, mclr_n, brownout_det, fetch_valid;
  logic fetch_parity, irq_wake, wdt_rc_osc, awvalid, awready, wvalid;
  logic wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic prog_mode, core_reset_n, core_sleep, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [13:0] fetch_word, opts;
  logic [33:0] exp_q[$];
  int          fails = 0, total_checks = 0, seed = 32'h4AAF;
  always #20 aclk = ~aclk;
  always @(posedge aclk) wdt_rc_osc <= ($random(seed) & 3) == 0;
  config_word_reset_options #(.POWERUP_DELAY_TIMER_CYCLES(20), .BOR_CYCLES(20)) i_dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .por_n, .mclr_n, .brownout_det, .prog_mode, .wdt_rc_osc, .fetch_valid,
    .fetch_word, .fetch_parity, .irq_wake, .core_reset_n, .core_sleep,
    .osc_mode_select(opts[1:0]), .watchdog_enable_cfg(opts[2]),
    .powerup_delay_enable(opts[3]), .brownout_reset_enable(opts[4]),
    .parity_check_enable(opts[5]), .code_protect_sel(opts[13:6]), .irq);
  cfg_programmer i_prog (.aclk, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .bvalid, .bready, .arvalid, .arready, .araddr,
    .rvalid, .rready, .prog_mode);
  task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    i_prog.rd(a, $random(seed) & 3);
  endtask
  always @(negedge aclk)
    if (rvalid && rready) chk("rdata", exp_q.pop_front(), {rresp, rdata});
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {aresetn, por_n, brownout_det, fetch_valid, fetch_parity} = 5'h00;
    {irq_wake, mclr_n, fetch_word} = 16'h4000;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("erased", 14'h3FFF, opts);
    por_n <= 1'b1;
    brownout_det <= 1'b1;
    repeat (3) @(posedge aclk);
    brownout_det <= 1'b0;
    wait (core_reset_n === 1'b1);
    @(posedge aclk);
    i_prog.burn(14'h3FB1);
    rd(8'h04, {2'h0, 32'h3FB1});
    i_prog.leave();
    repeat (3) @(posedge aclk);
    rd(8'h04, {2'h2, 32'h0});
    rd(8'h18 + 8'($random(seed) & 60), {2'h2, 32'h0});
    por_n <= 1'b0;
    repeat (6) @(posedge aclk);
    por_n <= 1'b1;
    wait (core_reset_n === 1'b1);
    @(posedge aclk);
    chk("options", 14'h3FE9, opts);
    i_prog.wr(8'h10, 32'h8);
    chk("irq masked", 0, irq);
    fetch_valid <= 1'b1;
    fetch_word <= 14'h0003;
    fetch_parity <= 1'b1;
    @(posedge aclk);
    fetch_valid <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("parity reset", 0, core_reset_n);
    chk("irq", 1, irq);
    rd(8'h0C, {2'h0, 32'hB});
    i_prog.wr(8'h0C, 32'hB);
    repeat (2) @(posedge aclk);
    chk("irq clear", 0, irq);
    wait (core_reset_n === 1'b1);
    @(posedge aclk);
    i_prog.wr(8'h14, 32'h1);
    repeat (3) @(posedge aclk);
    chk("sleep", 1, core_sleep);
    irq_wake <= 1'b1;
    repeat (4) @(posedge aclk);
    irq_wake <= 1'b0;
    chk("woken", 0, core_sleep);
    mclr_n <= 1'b0;
    repeat (4) @(posedge aclk);
    mclr_n <= 1'b1;
    rd(8'h0C, {2'h0, 32'h30});
    print_verdict();
  end
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
endmodule
